/* fmt_decode_chk.sv */
module fmt_decode_chk #(
    parameter int unsigned WIDE_BIT_POS = 8
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        wide_core,
    input wire logic        instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic [31:0] machine_state_word,
    input wire logic        dec_valid,
    input wire logic        dec_imm_format,
    input wire logic [4:0]  dest_reg,
    input wire logic        dest_wide,
    input wire logic [63:0] imm_value,
    input wire logic        imm_extended,
    input wire logic        carry_in,
    input wire logic        special_write
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic take;
    logic armed;
    // A taken word that is not the prefix
    assign take = instr_valid &&
        instr_word[31:26] != instr_decode_pkg::OPC_PREFIX;
    // Prefix stays armed over gaps until the next taken word
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) armed <= 1'b0;
        else if (instr_valid) armed <= !take;
    end
    sequence prefix_then_imm;
        instr_valid && !take ##1 take && instr_word[29];
    endsequence
    answer_pulse_a: assert property (take |=> dec_valid)
        else $error("decoded word gave no valid pulse");
    no_spurious_a: assert property (dec_valid |-> $past(take))
        else $error("valid pulse without a taken word");
    dest_field_a: assert property (take |=>
        dest_reg == $past(instr_word[25:21]) &&
        dec_imm_format == $past(instr_word[29]))
        else $error("destination or format field wrong");
    long_bit_a: assert property (take |=>
        dest_wide == $past(wide_core && instr_word[WIDE_BIT_POS]))
        else $error("destination width wrong");
    carry_track_a: assert property (!$past(rst) |->
        carry_in == $past(machine_state_word[29]))
        else $error("carry does not follow status bit");
    prefix_join_a: assert property (prefix_then_imm |=>
        imm_extended && imm_value[31:0] ==
        {$past(instr_word[15:0], 2), $past(instr_word[15:0])})
        else $error("prefixed immediate wrong");
    plain_imm_a: assert property (take && instr_word[29] && !armed |=>
        !imm_extended && imm_value[31:0] ==
        {{16{$past(instr_word[15])}}, $past(instr_word[15:0])})
        else $error("plain immediate wrong");
    spr_write_a: assert property (take |=> special_write ==
        ($past(instr_word[31:26]) == instr_decode_pkg::OPC_SPRMOV &&
        $past(instr_word[14])))
        else $error("special write flag wrong");
    hold_idle_a: assert property (!instr_valid |=>
        $stable(dest_reg) && !dec_valid)
        else $error("outputs moved without a word");
endmodule // fmt_decode_chk

/* instr_decode_pkg.sv */
package instr_decode_pkg;

    // Word and field widths
    localparam int unsigned WORD_W    = 32;
    localparam int unsigned WIDE_W    = 64;
    localparam int unsigned IMM_W     = 16;
    localparam int unsigned REG_IDX_W = 5;
    localparam int unsigned OPC_W     = 6;
    localparam int unsigned SPR_W     = 14;
    localparam int unsigned STREAM_W  = 4;
    localparam int unsigned VER_CNT   = 16;
    localparam int unsigned VER_IDX_W = 4;

    // Field positions inside the instruction word; FMT_BIT counts within the opcode
    localparam int unsigned OPC_LO    = 26;
    localparam int unsigned DST_LO    = 21;
    localparam int unsigned SRC1_LO   = 16;
    localparam int unsigned SRC2_LO   = 11;
    localparam int unsigned FMT_BIT   = 3;
    localparam int unsigned SPR_DIR   = 14;
    localparam int unsigned WIDE_POS  = 8;

    // Opcode groups and special opcodes
    localparam logic [1:0] GRP_ARITH  = 2'h0;
    localparam logic [1:0] GRP_MEM    = 2'h3;
    localparam logic [1:0] GRP_EXT    = 2'h1;
    localparam logic [2:0] BR_LO_A    = 3'h6;
    localparam logic [2:0] BR_LO_B    = 3'h7;
    localparam logic [5:0] OPC_PREFIX = 6'h2c;
    localparam logic [5:0] OPC_SPRMOV = 6'h25;
    localparam logic [5:0] OPC_STREAM = 6'h1b;

    // Special register numbers
    localparam logic [13:0] SPR_PC    = 14'h0000;
    localparam logic [13:0] SPR_MSW   = 14'h0001;
    localparam logic [13:0] SPR_FAW   = 14'h0003;
    localparam logic [13:0] SPR_ECW   = 14'h0005;
    localparam logic [13:0] SPR_FSW   = 14'h0007;
    localparam logic [13:0] SPR_BTW   = 14'h000b;
    localparam logic [13:0] SPR_VER   = 14'h2000;
    localparam int unsigned CARRY_BIT = 29;

    // Access sizes, low opcode bits of a load or store
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] SZ_LONG = 2'h3;

    typedef enum logic [2:0] {
        cat_arith   = 3'h0,
        cat_logic   = 3'h1,
        cat_branch  = 3'h2,
        cat_mem     = 3'h3,
        cat_special = 3'h4
    } category_t;

    typedef enum logic {
        pfx_idle = 1'b0,
        pfx_held = 1'b1
    } prefix_t;

endpackage : instr_decode_pkg

/* instruction_format_decode.sv */
module instruction_format_decode #(
    parameter int unsigned WIDE_BIT_POS = instr_decode_pkg::WIDE_POS
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        wide_core,
    input  wire logic        instr_valid,
    input  wire logic [31:0] instr_word,
    output logic [4:0]       source_one_idx,
    output logic [4:0]       source_two_idx,
    input  wire logic [63:0] source_one_data,
    input  wire logic [63:0] source_two_data,
    input  wire logic [31:0] pc_word,
    input  wire logic [31:0] machine_state_word,
    input  wire logic [31:0] exception_cause_word,
    input  wire logic [31:0] fault_address_word,
    input  wire logic [31:0] float_status_word,
    input  wire logic [31:0] branch_target_word,
    input  wire logic [15:0][31:0] version_word_n,
    output logic             dec_valid,
    output logic             dec_imm_format,
    output instr_decode_pkg::category_t dec_category,
    output logic [5:0]       dec_opcode,
    output logic [4:0]       dest_reg,
    output logic             dest_wide,
    output logic [63:0]      operand_one,
    output logic [63:0]      operand_two,
    output logic [63:0]      imm_value,
    output logic             imm_extended,
    output logic             signed_op,
    output logic             carry_in,
    output logic [13:0]      special_src,
    output logic [13:0]      special_dst,
    output logic             special_write,
    output logic [63:0]      special_value,
    output logic             special_known,
    output logic [3:0]       stream_port_select,
    output logic [1:0]       access_size,
    output logic             align_fault
);

    // Sign extension of a 32-bit value to the core's width
    function automatic logic [63:0] sext32(
        input logic [31:0] v,
        input logic        wide
    );
        logic [63:0] r;
        r = {{32{v[31]}}, v};
        if (!wide) begin
            r[63:32] = '0;
        end
        return r;
    endfunction

    // Source operand as the sized register view
    function automatic logic [63:0] view(
        input logic [63:0] d,
        input logic        wide,
        input logic        lng,
        input logic        sgn
    );
        logic [63:0] r;
        r = {32'h0000_0000, d[31:0]};
        if (wide && lng) begin
            r = d;
        end else if (sgn) begin
            r = sext32(d[31:0], wide);
        end
        return r;
    endfunction

    // Opcode to functional category
    function automatic instr_decode_pkg::category_t cat_of(
        input logic [5:0] op
    );
        instr_decode_pkg::category_t c;
        c = instr_decode_pkg::cat_logic;
        if (op[5:4] == instr_decode_pkg::GRP_MEM) begin
            c = instr_decode_pkg::cat_mem;
        end else if (op[5:4] == instr_decode_pkg::GRP_ARITH) begin
            c = instr_decode_pkg::cat_arith;
        end else if (op[5:4] == instr_decode_pkg::GRP_EXT ||
                     op == instr_decode_pkg::OPC_SPRMOV) begin
            c = instr_decode_pkg::cat_special;
        end else if (op[2:0] == instr_decode_pkg::BR_LO_A ||
                     op[2:0] == instr_decode_pkg::BR_LO_B) begin
            c = instr_decode_pkg::cat_branch;
        end
        return c;
    endfunction

    // Low address bits that must be zero for a size
    function automatic logic [2:0] align_mask(input logic [1:0] sz);
        logic [2:0] m;
        m = 3'h0;
        unique case (sz)
            instr_decode_pkg::SZ_BYTE: m = 3'h0;
            instr_decode_pkg::SZ_HALF: m = 3'h1;
            instr_decode_pkg::SZ_WORD: m = 3'h3;
            instr_decode_pkg::SZ_LONG: m = 3'h7;
        endcase
        return m;
    endfunction

    instr_decode_pkg::prefix_t   prefix_state;
    logic [15:0]                 prefix_upper;
    logic [5:0]                  opcode;
    logic                        is_imm;
    logic                        is_prefix;
    logic                        long_op;
    logic                        next_signed;
    instr_decode_pkg::category_t next_cat;
    logic [31:0]                 imm32;
    logic [63:0]                 next_imm;
    logic [63:0]                 next_one;
    logic [63:0]                 next_two;
    logic [13:0]                 spr_num;
    logic [3:0]                  ver_idx;
    logic [63:0]                 next_spr;
    logic                        next_known;
    logic [2:0]                  addr_low;
    logic                        next_misalign;

    assign opcode    = instr_word[instr_decode_pkg::OPC_LO +: 6];
    assign is_imm    = opcode[instr_decode_pkg::FMT_BIT];
    assign is_prefix = opcode == instr_decode_pkg::OPC_PREFIX;

    assign source_one_idx =
        instr_word[instr_decode_pkg::SRC1_LO +: 5];
    assign source_two_idx =
        instr_word[instr_decode_pkg::SRC2_LO +: 5];

    // long bit only counts on a wide core
    assign long_op = wide_core & instr_word[WIDE_BIT_POS];

    assign next_cat = cat_of(opcode);

    assign next_signed = next_cat == instr_decode_pkg::cat_arith;

    // prefix upper half joins the field
    // otherwise the field alone is extended
    always_comb begin
        imm32 = {{16{instr_word[15]}}, instr_word[15:0]};
        if (prefix_state == instr_decode_pkg::pfx_held) begin
            imm32 = {prefix_upper, instr_word[15:0]};
        end
    end

    assign next_imm = sext32(imm32, wide_core);

    always_comb begin
        next_one = view(source_one_data, wide_core,
                        long_op, next_signed);
        next_two = view(source_two_data, wide_core,
                        long_op, next_signed);
        if (is_imm) begin
            next_two = next_imm;
        end
    end

    // special number from the low field
    assign spr_num = instr_word[13:0];
    assign ver_idx = spr_num[3:0];

    // Special register read mux; unknown numbers read as zero
    // so a stray move cannot leak stale data
    always_comb begin
        next_spr   = '0;
        next_known = 1'b1;
        unique case (spr_num)
            instr_decode_pkg::SPR_PC:
                next_spr = {32'h0000_0000, pc_word};
            instr_decode_pkg::SPR_MSW:
                next_spr = {32'h0000_0000, machine_state_word};
            instr_decode_pkg::SPR_ECW:
                next_spr = {32'h0000_0000, exception_cause_word};
            instr_decode_pkg::SPR_FAW:
                next_spr = {32'h0000_0000, fault_address_word};
            instr_decode_pkg::SPR_FSW:
                next_spr = {32'h0000_0000, float_status_word};
            instr_decode_pkg::SPR_BTW:
                next_spr = {32'h0000_0000, branch_target_word};
            default: begin
                next_known = 1'b0;
                if ((spr_num & ~14'h000f) ==
                    instr_decode_pkg::SPR_VER) begin
                    next_spr   = {32'h0000_0000,
                                  version_word_n[ver_idx]};
                    next_known = 1'b1;
                end
            end
        endcase
    end

    assign addr_low = source_one_data[2:0] + next_two[2:0];
    assign next_misalign =
        (next_cat == instr_decode_pkg::cat_mem) &&
        ((addr_low & align_mask(opcode[1:0])) != 3'h0);

    // prefix holds for exactly one following word
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prefix_state <= instr_decode_pkg::pfx_idle;
        end else if (instr_valid) begin
            prefix_state <= is_prefix ? instr_decode_pkg::pfx_held
                                      : instr_decode_pkg::pfx_idle;
        end
    end

    // Upper half captured from the prefix word
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prefix_upper <= 16'h0000;
        end else if (instr_valid && is_prefix) begin
            prefix_upper <= instr_word[15:0];
        end
    end

    // A prefix is absorbed and produces no decoded word
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dec_valid <= 1'b0;
        end else begin
            dec_valid <= instr_valid & ~is_prefix;
        end
    end

    // Format, category and destination fields
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dec_imm_format <= 1'b0;
            dec_category   <= instr_decode_pkg::cat_arith;
            dec_opcode     <= 6'h00;
            dest_reg       <= 5'h00;
            dest_wide      <= 1'b0;
            signed_op      <= 1'b0;
        end else if (instr_valid) begin
            dec_imm_format <= is_imm;
            dec_category   <= next_cat;
            dec_opcode     <= opcode;
            dest_reg       <= instr_word[instr_decode_pkg::DST_LO +: 5];
            // full width only on long ops
            // narrow core writes its whole register
            dest_wide      <= long_op;
            signed_op      <= next_signed;
        end
    end

    // Operand and immediate values
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            operand_one  <= '0;
            operand_two  <= '0;
            imm_value    <= '0;
            imm_extended <= 1'b0;
        end else if (instr_valid) begin
            operand_one  <= next_one;
            operand_two  <= next_two;
            imm_value    <= is_imm ? next_imm : '0;
            imm_extended <= is_imm &&
                (prefix_state == instr_decode_pkg::pfx_held);
        end
    end

    // Special register selectors and read value
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            special_src   <= 14'h0000;
            special_dst   <= 14'h0000;
            special_write <= 1'b0;
            special_value <= '0;
            special_known <= 1'b0;
        end else if (instr_valid) begin
            // read and write selectors both load the same low field
            special_src   <= spr_num;
            special_dst   <= spr_num;
            special_write <= (opcode == instr_decode_pkg::OPC_SPRMOV)
                             && instr_word[instr_decode_pkg::SPR_DIR];
            special_value <= next_spr;
            special_known <= next_known;
        end
    end

    // Carry tracks the status word every cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            carry_in <= 1'b0;
        end else begin
            carry_in <= machine_state_word[instr_decode_pkg::CARRY_BIT];
        end
    end

    // Stream port and memory access checks
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stream_port_select <= 4'h0;
            access_size        <= instr_decode_pkg::SZ_BYTE;
            align_fault        <= 1'b0;
        end else if (instr_valid) begin
            stream_port_select <=
                (opcode == instr_decode_pkg::OPC_STREAM)
                ? instr_word[3:0] : 4'h0;
            access_size <= opcode[1:0];
            align_fault <= next_misalign;
        end
    end

endmodule // instruction_format_decode

/* instruction_format_decode_bench.sv */
module instruction_format_decode_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        wide_core = 1'b1;
    logic        instr_valid = 1'b0;
    logic [31:0] instr_word = 32'h0000_0000;
    logic [31:0] pc_word = 32'ha000_0000;
    logic [31:0] machine_state_word = 32'ha000_0001;
    logic [31:0] fault_address_word = 32'ha000_0003;
    logic [31:0] exception_cause_word = 32'ha000_0005;
    logic [31:0] float_status_word = 32'ha000_0007;
    logic [31:0] branch_target_word = 32'ha000_000b;
    logic [15:0][31:0] version_word_n;
    logic [4:0]  source_one_idx, source_two_idx, dest_reg;
    logic [63:0] source_one_data, source_two_data, operand_one;
    logic [63:0] operand_two, imm_value, special_value;
    logic        dec_valid, dec_imm_format, dest_wide, imm_extended;
    logic        signed_op, carry_in, special_write, special_known;
    logic        align_fault;
    logic [5:0]  dec_opcode;
    logic [13:0] special_src, special_dst;
    logic [3:0]  stream_port_select;
    logic [1:0]  access_size;
    instr_decode_pkg::category_t dec_category;
    int          num_errors = 0;
    int          n_checks = 0;
    int          cycles = 0;

    // Clock at 125 MHz
    always #4 mclk = ~mclk;
    instruction_format_decode uut (.mclk, .rst, .wide_core, .instr_valid,
        .instr_word, .source_one_idx, .source_two_idx, .source_one_data,
        .source_two_data, .pc_word, .machine_state_word,
        .exception_cause_word, .fault_address_word, .float_status_word,
        .branch_target_word, .version_word_n, .dec_valid, .dec_imm_format,
        .dec_category, .dec_opcode, .dest_reg, .dest_wide, .operand_one,
        .operand_two, .imm_value, .imm_extended, .signed_op, .carry_in,
        .special_src, .special_dst, .special_write, .special_value,
        .special_known, .stream_port_select, .access_size, .align_fault);
    regfile_model regs (.source_one_idx, .source_two_idx,
        .source_one_data, .source_two_data);

    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Cut a hang short; the whole run needs well under this
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            final_report;
        end
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] mk(input logic [5:0] op,
        input logic [4:0] rd, input logic [15:0] lo);
        return {op, rd, 5'd0, lo};
    endfunction
    // Word taken at the next rising edge, result seen at the negedge after
    task automatic issue(input logic [31:0] w);
        instr_valid = 1'b1;
        instr_word = w;
        @(negedge mclk);
    endtask
    task automatic idle;
        instr_valid = 1'b0;
        @(negedge mclk);
    endtask
    // Register format with register 31 on all three selectors
    task automatic opnd(input logic wc, input logic [5:0] op,
        input logic lng, input logic [63:0] e1, input logic [63:0] e2,
        input logic [1:0] sw);
        wide_core = wc;
        issue({op, 5'd31, 5'd31, 5'd31, 2'b00, lng, 8'h00});
        chk(operand_one, e1 | 64'h1f);
        chk(operand_two, e2 | 64'h1f);
        chk(64'({source_one_idx, source_two_idx, dest_reg}), 64'h7fff);
        chk(64'({signed_op, dest_wide}), 64'(sw));
        idle;
    endtask
    task automatic t_categories;
        logic [5:0] ops[7] = '{6'h00, 6'h20, 6'h26, 6'h27, 6'h30, 6'h10,
            6'h25};
        logic [2:0] cat[7] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h4};
        for (int k = 0; k < 7; k++) begin
            issue(mk(ops[k], 5'd2, 16'h0000));
            chk(64'({dec_category, dec_opcode, dec_valid}),
                64'({cat[k], ops[k], 1'b1}));
        end
        idle;
    endtask
    task automatic t_prefix;
        wide_core = 1'b1;
        issue(mk(6'h2c, 5'd0, 16'h8234));
        chk(64'(dec_valid), 64'd0);
        issue(mk(6'h28, 5'd4, 16'h5678));
        chk(imm_value, 64'hffff_ffff_8234_5678);
        chk(64'({imm_extended, dec_imm_format, dest_reg}), 64'h64);
        issue(mk(6'h28, 5'd4, 16'h9abc));
        chk(imm_value, 64'hffff_ffff_ffff_9abc);
        chk(operand_two, 64'hffff_ffff_ffff_9abc);
        chk(64'(imm_extended), 64'd0);
        issue(mk(6'h2c, 5'd0, 16'h0001));
        idle;
        issue(mk(6'h28, 5'd4, 16'h0002));
        chk(imm_value, 64'h0000_0000_0001_0002);
        idle;
    endtask
    task automatic t_special;
        logic [13:0] sn[9] = '{14'h0000, 14'h0001, 14'h0003, 14'h0005,
            14'h0007, 14'h000b, 14'h2000, 14'h200f, 14'h0002};
        logic [31:0] sv[9] = '{32'ha000_0000, 32'ha000_0001, 32'ha000_0003,
            32'ha000_0005, 32'ha000_0007, 32'ha000_000b, 32'h5000_0000,
            32'h5000_000f, 32'h0000_0000};
        for (int k = 0; k < 9; k++) begin
            issue(mk(6'h25, 5'd1, {2'b00, sn[k]}));
            chk(special_value, 64'(sv[k]));
            chk(64'({special_known, special_src}), 64'({k < 8, sn[k]}));
        end
        issue(mk(6'h25, 5'd1, 16'h4007));
        chk(64'({special_write, special_dst}), 64'h4007);
        chk(64'(carry_in), 64'd1);
        machine_state_word = 32'h0000_0001;
        idle;
        chk(64'(carry_in), 64'd0);
    endtask
    task automatic t_misc;
        logic [1:0] sz[6] = '{2'h2, 2'h2, 2'h0, 2'h1, 2'h3, 2'h3};
        logic [2:0] off[6] = '{3'h2, 3'h4, 3'h1, 3'h1, 3'h4, 3'h0};
        logic       bad[6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        // Register 0 reads with low bits zero, so the offset sets alignment
        for (int k = 0; k < 6; k++) begin
            issue(mk({4'hE, sz[k]}, 5'd3, {13'h0000, off[k]}));
            chk(64'({align_fault, access_size}), 64'({bad[k], sz[k]}));
        end
        issue(mk(6'h1b, 5'd0, 16'h000a));
        chk(64'(stream_port_select), 64'ha);
        issue(mk(6'h20, 5'd0, 16'h0005));
        chk(64'(stream_port_select), 64'h0);
        idle;
    endtask
    // Reset in mid-run must drop an armed prefix and clear the outputs
    task automatic t_reset;
        issue(mk(6'h2c, 5'd0, 16'h7777));
        instr_valid = 1'b0;
        rst = 1'b1;
        @(negedge mclk);
        chk(64'({dec_valid, dest_reg, imm_extended}), 64'h0);
        chk(imm_value, 64'h0);
        rst = 1'b0;
        issue(mk(6'h28, 5'd4, 16'h0003));
        chk(imm_value, 64'h0000_0000_0000_0003);
        chk(64'({imm_extended, dec_valid}), 64'h1);
        idle;
    endtask

    // Main sequence
    initial begin
        for (int k = 0; k < 16; k++) version_word_n[k] = 32'h5000_0000 | k;
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        opnd(1'b1, 6'h00, 1'b0, 64'hffff_ffff_8765_4300,
            64'h0000_0000_7654_3200, 2'b10);
        opnd(1'b1, 6'h00, 1'b1, 64'h1234_5600_8765_4300,
            64'h0abc_de00_7654_3200, 2'b11);
        opnd(1'b0, 6'h00, 1'b1, 64'h0000_0000_8765_4300,
            64'h0000_0000_7654_3200, 2'b10);
        opnd(1'b1, 6'h20, 1'b0, 64'h0000_0000_8765_4300,
            64'h0000_0000_7654_3200, 2'b00);
        t_categories;
        t_prefix;
        t_special;
        t_misc;
        t_reset;
        final_report;
    end
endmodule // instruction_format_decode_bench

bind instruction_format_decode fmt_decode_chk #(
    .WIDE_BIT_POS(WIDE_BIT_POS)
) chk_i (.mclk, .rst, .wide_core, .instr_valid, .instr_word,
    .machine_state_word, .dec_valid, .dec_imm_format, .dest_reg, .dest_wide,
    .imm_value, .imm_extended, .carry_in, .special_write);

/* regfile_model.sv */
module regfile_model (
    input  wire logic [4:0]  source_one_idx,
    input  wire logic [4:0]  source_two_idx,
    output logic      [63:0] source_one_data,
    output logic      [63:0] source_two_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // thirty-two registers
    // Low half carries the index so a wrong selector shows; negative low
    // half on port one exposes a missing sign extension
    assign source_one_data = {32'h1234_5600,
        32'h8765_4300 | 32'(source_one_idx)};
    assign source_two_data = {32'h0abc_de00,
        32'h7654_3200 | 32'(source_two_idx)};
endmodule // regfile_model
